/* sim/inm_nesting_mask_properties.sv */
// Purpose: Port checks for the nesting mask
// Assumes: Bound to inm_nesting_mask
// Notes: Nesting bit tracked from register writes
`timescale 1ns/1ps
`default_nettype none
module inm_nesting_mask_properties
  import inm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic irq_req_o,
  input wire logic [4:0] irq_vec_o,
  input wire logic in_service_o,
  input wire logic [31:0] nesting_pointer_mask_o
);
  logic nest_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nest_r <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == INM_ADDR_FIRST_MODE_CONTROL) begin
      nest_r <= reg_wdata_i[INM_NEST_BIT];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_reset_clear: assert property ($rose(rst_b_i) |-> nesting_pointer_mask_o == INM_PMASK_RST && !in_service_o)
    else $error("pointer mask not clear after reset");
  a_rsvd_bits: assert property ((nesting_pointer_mask_o & ~INM_DEFINED) == INM_ZERO)
    else $error("reserved pointer mask bit set");
  a_nest_below: assert property (in_service_o && $past(in_service_o) && $stable(irq_vec_o)
    |-> (nesting_pointer_mask_o >> irq_vec_o) == INM_ZERO) else $error("equal or lower priority unmasked");
  a_no_nest: assert property (!nest_r && $stable(nest_r) && in_service_o && $past(in_service_o)
    |-> nesting_pointer_mask_o == INM_ZERO) else $error("pointer mask open without nesting");
  a_pmask_read: assert property ($past(reg_rd_i) && $past(reg_addr_i) == INM_ADDR_PMASK
    |-> reg_rdata_o == $past(nesting_pointer_mask_o)) else $error("pointer mask read mismatch");
  a_req_serve: assert property (irq_req_o |-> ##[0:1] in_service_o)
    else $error("taken interrupt not in service");
  a_vec_defined: assert property (irq_req_o |-> INM_DEFINED[irq_vec_o])
    else $error("vector on undefined bit");
  a_req_pulse: assert property (irq_req_o |=> !irq_req_o)
    else $error("take pulse longer than one cycle");
  cover property (irq_req_o && in_service_o && $past(in_service_o));
  cover property (nest_r && in_service_o && nesting_pointer_mask_o != INM_ZERO);
  cover property (irq_req_o && irq_vec_o == 5'(INM_TMZH_BIT));
endmodule
bind inm_nesting_mask inm_nesting_mask_properties i_inm_nesting_mask_properties (.*);
`default_nettype wire

/* sim/inm_seq_model.sv */
// Purpose: Sequencer stand-in ending each routine
// Assumes: Routine length set by the bench, 0 never ends
// Notes: A new take restarts the count
`timescale 1ns/1ps
`default_nettype none
module inm_seq_model (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic irq_req_i,
  input wire logic [7:0] svc_len_i,
  output logic service_done_o
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 8'h00;
      service_done_o <= 1'b0;
    end else begin
      service_done_o <= cnt_r == 8'h01 && !irq_req_i;
      if (irq_req_i)
        cnt_r <= svc_len_i;
      else if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* sim/interrupt_nesting_mask_tb.sv */
// Purpose: Self-checking bench for the nesting mask
// Assumes: Partner ends each routine after svc_r cycles
// Notes: Vectors logged from the take pulse
`timescale 1ns/1ps
`default_nettype none
module interrupt_nesting_mask_tb
  import inm_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] a_r = 4'h0;
  logic [31:0] wd_r = 32'h0;
  logic wr_r = 1'b0;
  logic rd_r = 1'b0;
  logic [5:0] src_r = 6'h00;
  logic [7:0] svc_r = 8'h30;
  logic done_w, req_w, serv_w;
  logic [4:0] vec_w;
  logic [31:0] rdat_w, d, d2;
  logic [31:0] pm_w;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int tl = 0;
  int tp = 0;
  int per;
  int vq[$];
  int tbl[6] = '{0, 1, 2, 2, 3, 6};
  always #25 clk_sys_i = ~clk_sys_i;
  inm_nesting_mask i_inm_nesting_mask (.clk_sys_i, .rst_b_i, .reg_addr_i(a_r), .reg_wdata_i(wd_r),
    .reg_wr_i(wr_r), .reg_rd_i(rd_r), .reg_rdata_o(rdat_w), .emulator_request_pin_i(src_r[0]),
    .reset_pin_i(src_r[1]), .illegal_periph_access_flag_i(src_r[2]), .unaligned_access_flag_i(src_r[3]),
    .stack_full_i(src_r[4]), .breakpoint_i(src_r[5]), .service_done_i(done_w), .irq_req_o(req_w),
    .irq_vec_o(vec_w), .in_service_o(serv_w), .nesting_pointer_mask_o(pm_w));
  inm_seq_model i_inm_seq_model (.clk_sys_i, .rst_b_i, .irq_req_i(req_w), .svc_len_i(svc_r),
    .service_done_o(done_w));
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Monitor samples settled outputs mid-cycle
  always @(negedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (req_w) begin
      vq.push_back(vec_w);
      tp <= tl;
      tl <= cyc;
    end
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic cy(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    a_r <= a;
    wd_r <= v;
    wr_r <= 1'b1;
    cy(1);
    wr_r <= 1'b0;
    cy(1);
  endtask
  task automatic rd(logic [3:0] a, output logic [31:0] v);
    a_r <= a;
    rd_r <= 1'b1;
    cy(1);
    rd_r <= 1'b0;
    #1 v = rdat_w;
    cy(1);
  endtask
  task automatic rdc(logic [3:0] a, logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk("register", v, e);
  endtask
  task automatic take(int e);
    while (vq.size() == 0)
      cy(1);
    chk("vector", 32'(vq.pop_front()), 32'(e));
  endtask
  task automatic pulse(logic [5:0] s);
    src_r <= s;
    cy(1);
    src_r <= 6'h00;
    cy(1);
  endtask
  task automatic wait_idle();
    @(negedge clk_sys_i);
    while (serv_w)
      @(negedge clk_sys_i);
    cy(1);
  endtask
  // Model: pointer mask with every defined bit unmasked
  function automatic logic [31:0] m_pmask(int idx, bit nest);
    return nest ? (INM_DEFINED & ((32'h1 << idx) - 32'h1)) : INM_ZERO;
  endfunction
  task automatic pmc(logic [31:0] e);
    rdc(INM_ADDR_PMASK, e);
    chk("pointer mask pin", pm_w, e);
  endtask
  initial begin
    void'($urandom(21));
    cy(20);
    rst_b_i <= 1'b1;
    cy(1);
    rdc(INM_ADDR_PMASK, INM_PMASK_RST);
    rdc(INM_ADDR_LATCH, INM_LATCH_RST);
    wr(INM_ADDR_PMASK, 32'hffff_ffff);
    rdc(INM_ADDR_PMASK, INM_ZERO);
    rdc(4'h9, INM_ZERO);
    wr(INM_ADDR_FIRST_MODE_CONTROL, 32'h1);
    wr(INM_ADDR_MASK, INM_DEFINED);
    take(INM_EMU_BIT);
    take(INM_RST_BIT);
    cy(3);
    pmc(m_pmask(INM_RST_BIT, 1'b1));
    pulse(6'h10);
    cy(4);
    rdc(INM_ADDR_LATCH, 32'h8);
    take(INM_STK_BIT);
    cy(3);
    pmc(m_pmask(INM_STK_BIT, 1'b1));
    pulse(6'h04);
    cy(6);
    chk("preempt", 32'(vq.size()), 32'h1);
    take(INM_IIC_BIT);
    wr(INM_ADDR_FIRST_MODE_CONTROL, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wait_idle();
      svc_r <= 8'(20 + $urandom % 40);
      pulse(6'(1 << i));
      take(tbl[i]);
      cy(3);
      pmc(m_pmask(tbl[i], 1'b0));
    end
    pulse(6'h11);
    cy(6);
    chk("blocked", 32'(vq.size()), 32'h0);
    take(INM_EMU_BIT);
    take(INM_STK_BIT);
    wait_idle();
    svc_r <= 8'h02;
    per = 5 + $urandom % 8;
    wr(INM_ADDR_TIMER_PERIOD_REG, 32'hffff_ffff);
    rdc(INM_ADDR_TIMER_PERIOD_REG, 32'hffff_ffff);
    wr(INM_ADDR_TIMER_PERIOD_REG, 32'(per));
    wr(INM_ADDR_TIMER_COUNT_REG, 32'(per));
    wr(INM_ADDR_MASK, 32'h10);
    wr(INM_ADDR_SECOND_MODE_CONTROL, 32'h1);
    take(INM_TMZH_BIT);
    take(INM_TMZH_BIT);
    chk("period", 32'(tl - tp), 32'(per + 1));
    rd(INM_ADDR_LATCH, d);
    chk("low timer", 32'(d[INM_TMZL_BIT]), 32'h1);
    rd(INM_ADDR_TIMER_COUNT_REG, d);
    rd(INM_ADDR_TIMER_COUNT_REG, d2);
    chk("count", d2, (d + 32'(per) - 32'h1) % 32'(per + 1));
    wr(INM_ADDR_SECOND_MODE_CONTROL, 32'h0);
    rd(INM_ADDR_TIMER_COUNT_REG, d);
    rd(INM_ADDR_TIMER_COUNT_REG, d2);
    chk("stopped", d2, d);
    end_of_test();
  end
endmodule
`default_nettype wire

/* src/inm_nesting_mask.sv */
// Purpose: Interrupt nesting mask, pending latch and core timer
// Assumes: Pins are asynchronous and pass two flip-flops
// Notes: Lower bit index means higher priority
//
// Function
// - Nesting on: mask lower-priority interrupts, unmask higher ones during service.
// - Nesting enable bit lives in the first mode control register.
// - Latch masked requests; service them once unmasked.
// - Nesting off: block all interrupts while any is serviced.
// - Nesting off: after service take highest-priority latched interrupt.
// - Bit 0 emulator interrupt raised on reset and emulator pin.
// - Bit 1 reset interrupt raised by the reset pin.
// - Bit 2 raised by OR of two sticky illegal-access flags.
// - Bit 3 raised when any sequencer stack overflows or fills.
// - Bit 4 timer zero raises both high and low timer interrupts.
// - Enabled timer decrements its count every cycle.
// - Timer interrupts spaced period plus one cycles.
// - Period register is full 32-bit unsigned.
// - Timer enable bit in second mode register starts and stops timer.
// - Bit 6 breakpoint; bits 5 and 7 reserved.
// - Pointer mask bit reads 1 unmasked, 0 masked, during service.
// - Pointer mask clears to zero at reset.
// - Pointer mask bits align with pending latch bits.
`timescale 1ns/1ps
`default_nettype none
module inm_nesting_mask
  import inm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Interrupt sources
  input wire logic emulator_request_pin_i,
  input wire logic reset_pin_i,
  input wire logic illegal_periph_access_flag_i,
  input wire logic unaligned_access_flag_i,
  input wire logic stack_full_i,
  input wire logic breakpoint_i,
  // Sequencer handshake
  input wire logic service_done_i,
  output logic irq_req_o,
  output logic [4:0] irq_vec_o,
  output logic in_service_o,
  output logic [31:0] nesting_pointer_mask_o
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] pins;
  assign pins = {breakpoint_i, stack_full_i, unaligned_access_flag_i,
                 illegal_periph_access_flag_i, reset_pin_i, emulator_request_pin_i};
  // Only the second stage feeds logic
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic nest_en_r;
  logic timer_en_r;
  logic [31:0] latch_r;
  logic [31:0] latch_nxt;
  logic [31:0] mask_r;
  logic [31:0] pmask_r;
  logic [31:0] pmask_nxt;
  logic [31:0] timer_count_reg_r;
  logic [31:0] timer_period_reg_r;
  logic [5:0] serv_idx_r;
  logic [4:0] vec_r;
  logic req_r;
  logic [31:0] rdata_r;
  logic [31:0] raise;
  logic [31:0] eligible;
  logic [5:0] pick_idx;
  logic tmr_zero;

  // Highest priority set bit, lowest index wins
  function automatic logic [5:0] inm_first(input logic [31:0] v);
    logic [5:0] r;
    r = INM_IDLE_IDX;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // Mask of positions strictly above a priority index
  function automatic logic [31:0] inm_above(input logic [5:0] idx);
    logic [31:0] r;
    r = INM_ZERO;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) < idx) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // Write strobe aimed at one register index
  function automatic logic inm_wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] idx);
    return wr && (addr == idx);
  endfunction

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  logic wr_first_mode_control;
  logic wr_second_mode_control;
  logic wr_latch;
  logic wr_mask;
  logic wr_timer_count_reg;
  logic wr_timer_period_reg;
  assign wr_first_mode_control = inm_wr_hit(reg_wr_i, reg_addr_i, INM_ADDR_FIRST_MODE_CONTROL);
  assign wr_second_mode_control = inm_wr_hit(reg_wr_i, reg_addr_i, INM_ADDR_SECOND_MODE_CONTROL);
  assign wr_latch = inm_wr_hit(reg_wr_i, reg_addr_i, INM_ADDR_LATCH);
  assign wr_mask = inm_wr_hit(reg_wr_i, reg_addr_i, INM_ADDR_MASK);
  assign wr_timer_count_reg = inm_wr_hit(reg_wr_i, reg_addr_i, INM_ADDR_TIMER_COUNT_REG);
  assign wr_timer_period_reg = inm_wr_hit(reg_wr_i, reg_addr_i, INM_ADDR_TIMER_PERIOD_REG);

  // ------------------------------------------------------------
  // Mode, mask and timer period registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nest_en_r <= 1'b0;
    end else if (wr_first_mode_control) begin
      nest_en_r <= reg_wdata_i[INM_NEST_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_en_r <= 1'b0;
    end else if (wr_second_mode_control) begin
      timer_en_r <= reg_wdata_i[INM_TIMER_ENABLE_BIT_BIT];
    end
  end

  // Only defined bits can be unmasked
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_r <= INM_ZERO;
    end else if (wr_mask) begin
      mask_r <= reg_wdata_i & INM_DEFINED;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_period_reg_r <= INM_TIMER_PERIOD_REG_RST;
    end else if (wr_timer_period_reg) begin
      timer_period_reg_r <= reg_wdata_i;
    end
  end

  // ------------------------------------------------------------
  // Core timer
  // ------------------------------------------------------------
  // Software write beats reload and countdown
  assign tmr_zero = timer_en_r && (timer_count_reg_r == INM_ZERO);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_count_reg_r <= INM_ZERO;
    end else if (wr_timer_count_reg) begin
      timer_count_reg_r <= reg_wdata_i;
    end else if (tmr_zero) begin
      timer_count_reg_r <= timer_period_reg_r;
    end else if (timer_en_r) begin
      timer_count_reg_r <= timer_count_reg_r - 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // Pending latch and service
  // ------------------------------------------------------------
  always_comb begin
    raise = INM_ZERO;
    raise[INM_EMU_BIT] = sync2_r[0];
    raise[INM_RST_BIT] = sync2_r[1];
    raise[INM_IIC_BIT] = sync2_r[2] | sync2_r[3];
    raise[INM_STK_BIT] = sync2_r[4];
    raise[INM_TMZH_BIT] = tmr_zero;
    raise[INM_TMZL_BIT] = tmr_zero;
    raise[INM_BKP_BIT] = sync2_r[5];
  end

  // ------------------------------------------------------------
  // Interrupt selection
  // ------------------------------------------------------------
  // Nesting on: only above current; off: nothing while in service
  always_comb begin
    if (serv_idx_r == INM_IDLE_IDX) begin
      pmask_nxt = INM_PMASK_RST;
    end else if (nest_en_r) begin
      pmask_nxt = mask_r & inm_above(serv_idx_r);
    end else begin
      pmask_nxt = INM_ZERO;
    end
  end

  // Pointer mask lags the service index by one cycle, so picking
  // pauses while the take pulse stands and never sees a stale mask
  always_comb begin
    if (req_r) begin
      eligible = INM_ZERO;
    end else if (serv_idx_r == INM_IDLE_IDX) begin
      eligible = latch_r & mask_r;
    end else begin
      eligible = latch_r & pmask_r;
    end
  end
  assign pick_idx = inm_first(eligible);

  always_comb begin
    latch_nxt = latch_r;
    if (wr_latch) begin
      latch_nxt = reg_wdata_i & INM_DEFINED;
    end
    if (pick_idx != INM_IDLE_IDX) begin
      latch_nxt[pick_idx[4:0]] = 1'b0;
    end
    // Raise applied last so a new event beats the take clear
    latch_nxt = latch_nxt | raise;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_r <= INM_LATCH_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // ------------------------------------------------------------
  // Service tracking
  // ------------------------------------------------------------
  // Single level of service tracked; nested entry replaces index
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serv_idx_r <= INM_IDLE_IDX;
    end else if (pick_idx != INM_IDLE_IDX) begin
      serv_idx_r <= pick_idx;
    end else if (service_done_i) begin
      serv_idx_r <= INM_IDLE_IDX;
    end
  end

  // Take pulse, one cycle per picked interrupt
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_r <= 1'b0;
    end else begin
      req_r <= (pick_idx != INM_IDLE_IDX);
    end
  end

  // Vector holds until the next take
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_r <= 5'h00;
    end else if (pick_idx != INM_IDLE_IDX) begin
      vec_r <= pick_idx[4:0];
    end
  end

  // ------------------------------------------------------------
  // Pointer mask register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pmask_r <= INM_PMASK_RST;
    end else begin
      pmask_r <= pmask_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Read data stands one cycle, zero otherwise
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= INM_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        INM_ADDR_FIRST_MODE_CONTROL: rdata_r <= {31'h0, nest_en_r};
        INM_ADDR_SECOND_MODE_CONTROL: rdata_r <= {31'h0, timer_en_r};
        INM_ADDR_PMASK: rdata_r <= pmask_r;
        INM_ADDR_LATCH: rdata_r <= latch_r;
        INM_ADDR_MASK: rdata_r <= mask_r;
        INM_ADDR_TIMER_COUNT_REG: rdata_r <= timer_count_reg_r;
        INM_ADDR_TIMER_PERIOD_REG: rdata_r <= timer_period_reg_r;
        INM_ADDR_STATUS: rdata_r <= {26'h0, serv_idx_r};
        default: rdata_r <= INM_ZERO;
      endcase
    end else begin
      rdata_r <= INM_ZERO;
    end
  end

  // ------------------------------------------------------------
  // In-service flag
  // ------------------------------------------------------------
  logic svc_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      svc_r <= 1'b0;
    end else begin
      svc_r <= (pick_idx != INM_IDLE_IDX) || (serv_idx_r != INM_IDLE_IDX && !service_done_i);
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata_o = rdata_r;
  assign irq_req_o = req_r;
  assign irq_vec_o = vec_r;
  assign in_service_o = svc_r;
  assign nesting_pointer_mask_o = pmask_r;

endmodule
`default_nettype wire

/* src/inm_pkg.sv */
// Purpose: Constants for the interrupt nesting mask block
// Assumes: One core clock, 32-bit register port
// Notes: Register offsets are word indices on the plain port
package inm_pkg;
  localparam int unsigned INM_W = 32;
  localparam logic [3:0] INM_ADDR_FIRST_MODE_CONTROL = 4'h0;
  localparam logic [3:0] INM_ADDR_SECOND_MODE_CONTROL = 4'h1;
  localparam logic [3:0] INM_ADDR_PMASK = 4'h2;
  localparam logic [3:0] INM_ADDR_LATCH = 4'h3;
  localparam logic [3:0] INM_ADDR_MASK = 4'h4;
  localparam logic [3:0] INM_ADDR_TIMER_COUNT_REG = 4'h5;
  localparam logic [3:0] INM_ADDR_TIMER_PERIOD_REG = 4'h6;
  localparam logic [3:0] INM_ADDR_STATUS = 4'h7;
  localparam int unsigned INM_NEST_BIT = 0;
  localparam int unsigned INM_TIMER_ENABLE_BIT_BIT = 0;
  localparam int unsigned INM_EMU_BIT = 0;
  localparam int unsigned INM_RST_BIT = 1;
  localparam int unsigned INM_IIC_BIT = 2;
  localparam int unsigned INM_STK_BIT = 3;
  localparam int unsigned INM_TMZH_BIT = 4;
  localparam int unsigned INM_BKP_BIT = 6;
  localparam int unsigned INM_TMZL_BIT = 22;
  localparam logic [31:0] INM_DEFINED = 32'h0040_005f;
  localparam logic [31:0] INM_PMASK_RST = 32'h0000_0000;
  localparam logic [31:0] INM_LATCH_RST = 32'h0000_0003;
  localparam logic [31:0] INM_ZERO = 32'h0000_0000;
  localparam logic [31:0] INM_TIMER_PERIOD_REG_RST = 32'h0000_0000;
  localparam logic [5:0] INM_IDLE_IDX = 6'h3f;
endpackage
